// ===== hw/uart_lin_pkg.sv
package uart_lin_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTL = 8'h04;
    localparam logic [7:0] ADDR_ERR = 8'h08;
    localparam logic [7:0] ADDR_CLKSEL = 8'h0C;
    localparam logic [7:0] ADDR_DIV = 8'h10;
    localparam logic [7:0] ADDR_TXBUF = 8'h14;
    localparam logic [7:0] ADDR_RXBUF = 8'h18;
    localparam logic [7:0] ADDR_TXSTAT = 8'h1C;

    // serial_mode_reg fields
    localparam int MODE_POWER_BIT = 7;
    localparam int MODE_TXE_BIT = 6;
    localparam int MODE_RXE_BIT = 5;
    localparam int MODE_PAR_EN_BIT = 4;
    localparam int MODE_PAR_ODD_BIT = 3;
    localparam int MODE_MERGE_BIT = 0;

    // serial_ctl_reg fields
    localparam int CTL_BRK_FLAG_BIT = 7;
    localparam int CTL_BRK_RX_EN_BIT = 6;
    localparam int CTL_BRK_TX_BIT = 5;
    localparam int CTL_BRK_LEN_MSB = 4;
    localparam int CTL_BRK_LEN_LSB = 2;

    // rx_error_status fields
    localparam int ERR_OVERRUN_BIT = 0;
    localparam int ERR_PARITY_BIT = 1;
    localparam int ERR_FRAMING_BIT = 2;

    // txstat fields
    localparam int TXSTAT_BUSY_BIT = 0;
    localparam int TXSTAT_FULL_BIT = 1;

    localparam logic [4:0] DATA_BITS = 5'd8;
    localparam logic [4:0] BREAK_TX_BASE = 5'd13;
    localparam logic [4:0] BREAK_RX_VALID = 5'd11;
    localparam logic [4:0] BREAK_RX_SAT = 5'd31;
    localparam logic [4:0] GAP_TICKS = 5'd2;
    localparam logic [7:0] DIV_MIN = 8'h04;
    localparam logic [7:0] DIV_RESET = 8'hFF;
    localparam logic [7:0] RX_BUF_RESET = 8'hFF;
    localparam logic [9:0] PRE_ALL_ONES = 10'h3FF;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_GAP, TX_BREAK}
        tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_CHECK, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK}
        rx_state_type;

endpackage

// ===== hw/uart_lin_break_and_baud_gen.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module uart_lin_break_and_baud_gen
    import uart_lin_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic tx_done_irq,
    output logic rx_done_irq,
    output logic rx_err_irq
);

    typedef struct packed {
        logic unit_power_bit;
        logic tx_enable_bit;
        logic rx_enable_bit;
        logic par_en;
        logic par_odd;
        logic err_irq_merge_sel;
        logic break_tx_trigger;
        logic break_rx_enable;
        logic break_rx_flag;
        logic [2:0] break_len;
        logic [3:0] prescale_sel;
        logic [7:0] divisor;
        logic [9:0] pre_cnt;
        logic base_tick;
        tx_state_type tx_state;
        logic [7:0] tx_cnt;
        logic tx_half;
        logic [4:0] tx_bits;
        logic [7:0] tx_shift;
        logic tx_par;
        logic [7:0] tx_buffer;
        logic tx_buf_full;
        logic tx_pin;
        logic tx_done;
        rx_state_type rx_state;
        logic [7:0] rx_cnt;
        logic rx_half;
        logic [4:0] rx_bits;
        logic [7:0] rx_shifter;
        logic rx_par_bit;
        logic filt_s1;
        logic filt_s2;
        logic rx_line;
        logic rx_prev;
        logic [7:0] rx_buffer;
        logic rx_full;
        logic [2:0] rx_error_status;
        logic rx_done;
        logic rx_err;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } state_type;

    state_type q_q;
    state_type q_d;

    function automatic logic base_hit(input logic [9:0] cnt, input logic [3:0] sel);
        logic [9:0] mask;
        mask = ~(PRE_ALL_ONES << sel);
        return (cnt & mask) == mask;
    endfunction

    function automatic logic baud_hit(input logic [7:0] cnt, input logic [7:0] k);
        return cnt == (k - 8'h01);
    endfunction

    function automatic logic parity_of(input logic [7:0] data, input logic odd);
        return (^data) ^ odd;
    endfunction

    always_comb
    begin
        logic access;
        logic done;
        logic tx_run;
        logic rx_run;
        logic tx_hit;
        logic rx_hit;
        logic tx_bit_end;
        logic rx_sample;
        logic tx_load;
        logic [2:0] errs;
        logic [31:0] rd;
        access = 1'b0;
        done = 1'b0;
        tx_run = 1'b0;
        rx_run = 1'b0;
        tx_hit = 1'b0;
        rx_hit = 1'b0;
        tx_bit_end = 1'b0;
        rx_sample = 1'b0;
        tx_load = 1'b0;
        errs = 3'h0;
        rd = 32'h0;
        q_d = q_q;
        q_d.tx_done = 1'b0;
        q_d.rx_done = 1'b0;
        q_d.rx_err = 1'b0;
        q_d.pready = 1'b0;
        q_d.pslverr = 1'b0;

        // APB: one wait state, so every access completes on its second access-phase edge
        access = psel & penable & ~q_q.pready;
        done = psel & penable & q_q.pready;
        if (access)
        begin
            q_d.pready = 1'b1;
            case (paddr)
                ADDR_MODE:
                begin
                    rd[MODE_POWER_BIT] = q_q.unit_power_bit;
                    rd[MODE_TXE_BIT] = q_q.tx_enable_bit;
                    rd[MODE_RXE_BIT] = q_q.rx_enable_bit;
                    rd[MODE_PAR_EN_BIT] = q_q.par_en;
                    rd[MODE_PAR_ODD_BIT] = q_q.par_odd;
                    rd[MODE_MERGE_BIT] = q_q.err_irq_merge_sel;
                end
                ADDR_CTL:
                begin
                    rd[CTL_BRK_FLAG_BIT] = q_q.break_rx_flag;
                    rd[CTL_BRK_RX_EN_BIT] = q_q.break_rx_enable;
                    rd[CTL_BRK_TX_BIT] = q_q.break_tx_trigger;
                    rd[CTL_BRK_LEN_MSB:CTL_BRK_LEN_LSB] = q_q.break_len;
                end
                ADDR_ERR: rd = 32'(q_q.rx_error_status);
                ADDR_CLKSEL: rd = 32'(q_q.prescale_sel);
                ADDR_DIV: rd = 32'(q_q.divisor);
                ADDR_TXBUF: rd = 32'(q_q.tx_buffer);
                ADDR_RXBUF: rd = 32'(q_q.rx_buffer);
                ADDR_TXSTAT:
                begin
                    rd[TXSTAT_BUSY_BIT] = q_q.tx_state != TX_IDLE;
                    rd[TXSTAT_FULL_BIT] = q_q.tx_buf_full;
                end
                default: q_d.pslverr = 1'b1;
            endcase
            q_d.prdata = rd;
        end
        if (done & pwrite)
        begin
            case (paddr)
                ADDR_MODE:
                begin
                    q_d.unit_power_bit = pwdata[MODE_POWER_BIT];
                    // Enables only stick once power was already on
                    q_d.tx_enable_bit = pwdata[MODE_TXE_BIT] & q_q.unit_power_bit;
                    q_d.rx_enable_bit = pwdata[MODE_RXE_BIT] & q_q.unit_power_bit;
                    q_d.par_en = pwdata[MODE_PAR_EN_BIT];
                    q_d.par_odd = pwdata[MODE_PAR_ODD_BIT];
                    q_d.err_irq_merge_sel = pwdata[MODE_MERGE_BIT];
                end
                ADDR_CTL:
                begin
                    if (pwdata[CTL_BRK_TX_BIT] & q_q.unit_power_bit & q_q.tx_enable_bit)
                    begin
                        q_d.break_tx_trigger = 1'b1;
                    end
                    q_d.break_rx_enable = pwdata[CTL_BRK_RX_EN_BIT];
                    q_d.break_len = pwdata[CTL_BRK_LEN_MSB:CTL_BRK_LEN_LSB];
                end
                ADDR_CLKSEL: q_d.prescale_sel = pwdata[3:0];
                // Below the minimum the bit timing breaks down, so clamp
                ADDR_DIV: q_d.divisor = (pwdata[7:0] < DIV_MIN) ? DIV_MIN : pwdata[7:0];
                ADDR_TXBUF:
                begin
                    q_d.tx_buffer = pwdata[7:0];
                    q_d.tx_buf_full = 1'b1;
                end
                default: q_d.pslverr = 1'b0;
            endcase
        end
        if (done & ~pwrite)
        begin
            if (paddr == ADDR_ERR)
            begin
                q_d.rx_error_status = 3'h0;
            end
            if (paddr == ADDR_RXBUF)
            begin
                q_d.rx_full = 1'b0;
            end
        end

        // Prescaler and base clock
        q_d.pre_cnt = q_q.unit_power_bit ? q_q.pre_cnt + 10'h001 : 10'h000;
        q_d.base_tick = q_q.unit_power_bit & base_hit(q_q.pre_cnt, q_q.prescale_sel);

        // Noise filter: a level passes only after two equal samples
        if (q_q.base_tick)
        begin
            q_d.filt_s1 = serial_in_pin;
            q_d.filt_s2 = q_q.filt_s1;
            if (q_q.filt_s1 == q_q.filt_s2)
            begin
                q_d.rx_line = q_q.filt_s1;
            end
        end

        // Transmitter
        tx_run = q_q.unit_power_bit & q_q.tx_enable_bit;
        if (!tx_run)
        begin
            q_d.tx_state = TX_IDLE;
            q_d.tx_cnt = 8'h00;
            q_d.tx_half = 1'b0;
            q_d.tx_pin = 1'b1;
        end
        else
        begin
            if (q_q.base_tick)
            begin
                tx_hit = baud_hit(q_q.tx_cnt, q_q.divisor);
                q_d.tx_cnt = tx_hit ? 8'h00 : q_q.tx_cnt + 8'h01;
                q_d.tx_half = q_q.tx_half ^ tx_hit;
                tx_bit_end = tx_hit & q_q.tx_half;
            end
            case (q_q.tx_state)
                TX_IDLE:
                begin
                    // Idle counter free-runs; only a start or a break clears it
                    if (q_q.break_tx_trigger)
                    begin
                        q_d.tx_state = TX_BREAK;
                        q_d.tx_cnt = 8'h00;
                        q_d.tx_half = 1'b0;
                        q_d.tx_bits = 5'd0;
                        q_d.tx_pin = 1'b0;
                    end
                    else
                    begin
                        tx_load = q_q.tx_buf_full;
                    end
                end
                TX_START:
                begin
                    if (tx_bit_end)
                    begin
                        q_d.tx_state = TX_DATA;
                        q_d.tx_pin = q_q.tx_shift[0];
                    end
                end
                TX_DATA:
                begin
                    if (tx_bit_end)
                    begin
                        q_d.tx_bits = q_q.tx_bits + 5'd1;
                        q_d.tx_shift = q_q.tx_shift >> 1;
                        q_d.tx_pin = q_q.tx_shift[1];
                        if (q_q.tx_bits == DATA_BITS - 5'd1)
                        begin
                            q_d.tx_state = q_q.par_en ? TX_PARITY : TX_STOP;
                            q_d.tx_pin = q_q.par_en ? q_q.tx_par : 1'b1;
                        end
                    end
                end
                TX_PARITY:
                begin
                    if (tx_bit_end)
                    begin
                        q_d.tx_state = TX_STOP;
                        q_d.tx_pin = 1'b1;
                    end
                end
                TX_STOP:
                begin
                    if (tx_bit_end)
                    begin
                        q_d.tx_done = 1'b1;
                        q_d.tx_bits = 5'd0;
                        q_d.tx_state = q_q.tx_buf_full ? TX_GAP : TX_IDLE;
                    end
                end
                TX_GAP:
                begin
                    // Reload costs two extra base clocks between frames
                    if (q_q.base_tick)
                    begin
                        q_d.tx_bits = q_q.tx_bits + 5'd1;
                        tx_load = q_q.tx_bits == GAP_TICKS - 5'd1;
                    end
                end
                TX_BREAK:
                begin
                    if (tx_bit_end)
                    begin
                        q_d.tx_bits = q_q.tx_bits + 5'd1;
                        if (q_q.tx_bits + 5'd1 == BREAK_TX_BASE + 5'(q_q.break_len))
                        begin
                            q_d.tx_pin = 1'b1;
                            q_d.tx_done = 1'b1;
                            q_d.break_tx_trigger = 1'b0;
                            q_d.tx_state = TX_IDLE;
                        end
                    end
                end
                default: q_d.tx_state = TX_IDLE;
            endcase
            if (tx_load)
            begin
                q_d.tx_shift = q_d.tx_buffer;
                q_d.tx_par = parity_of(q_d.tx_buffer, q_q.par_odd);
                q_d.tx_buf_full = 1'b0;
                q_d.tx_bits = 5'd0;
                q_d.tx_cnt = 8'h00;
                q_d.tx_half = 1'b0;
                q_d.tx_pin = 1'b0;
                q_d.tx_state = TX_START;
            end
        end

        // Receiver
        rx_run = q_q.unit_power_bit & q_q.rx_enable_bit;
        if (q_q.base_tick)
        begin
            q_d.rx_prev = q_q.rx_line;
        end
        if (!rx_run)
        begin
            q_d.rx_state = RX_IDLE;
            q_d.rx_cnt = 8'h00;
            q_d.rx_half = 1'b0;
        end
        else
        begin
            if (q_q.base_tick && q_q.rx_state != RX_IDLE)
            begin
                rx_hit = baud_hit(q_q.rx_cnt, q_q.divisor);
                q_d.rx_cnt = rx_hit ? 8'h00 : q_q.rx_cnt + 8'h01;
                q_d.rx_half = q_q.rx_half ^ rx_hit;
                // Samples fall mid-bit: first after k, then every 2k
                rx_sample = rx_hit & ~q_q.rx_half;
            end
            case (q_q.rx_state)
                RX_IDLE:
                begin
                    if (q_q.base_tick && q_q.rx_prev && !q_q.rx_line)
                    begin
                        q_d.rx_state = RX_CHECK;
                        q_d.rx_cnt = 8'h00;
                        q_d.rx_half = 1'b0;
                    end
                end
                RX_CHECK:
                begin
                    if (rx_sample)
                    begin
                        q_d.rx_bits = 5'd0;
                        if (q_q.rx_line)
                        begin
                            q_d.rx_state = RX_IDLE;
                            q_d.rx_cnt = 8'h00;
                            q_d.rx_half = 1'b0;
                        end
                        else if (q_q.break_rx_enable)
                        begin
                            q_d.rx_state = RX_BREAK;
                            q_d.rx_bits = 5'd1;
                            q_d.break_rx_flag = 1'b1;
                        end
                        else
                        begin
                            q_d.rx_state = RX_DATA;
                        end
                    end
                end
                RX_DATA:
                begin
                    if (rx_sample)
                    begin
                        q_d.rx_shifter = {q_q.rx_line, q_q.rx_shifter[7:1]};
                        q_d.rx_bits = q_q.rx_bits + 5'd1;
                        if (q_q.rx_bits == DATA_BITS - 5'd1)
                        begin
                            q_d.rx_state = q_q.par_en ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY:
                begin
                    if (rx_sample)
                    begin
                        q_d.rx_par_bit = q_q.rx_line;
                        q_d.rx_state = RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    if (rx_sample)
                    begin
                        errs[ERR_OVERRUN_BIT] = q_q.rx_full;
                        errs[ERR_PARITY_BIT] = q_q.par_en &
                            (q_q.rx_par_bit != parity_of(q_q.rx_shifter, q_q.par_odd));
                        errs[ERR_FRAMING_BIT] = ~q_q.rx_line;
                        q_d.rx_error_status = q_d.rx_error_status | errs;
                        if (!q_q.rx_full)
                        begin
                            q_d.rx_buffer = q_q.rx_shifter;
                            q_d.rx_full = 1'b1;
                        end
                        if (errs != 3'h0 && !q_q.err_irq_merge_sel)
                        begin
                            q_d.rx_err = 1'b1;
                        end
                        else
                        begin
                            q_d.rx_done = 1'b1;
                        end
                        q_d.rx_state = RX_IDLE;
                        q_d.rx_cnt = 8'h00;
                        q_d.rx_half = 1'b0;
                    end
                end
                RX_BREAK:
                begin
                    // No error flags and no buffer update in this state
                    if (rx_sample)
                    begin
                        if (!q_q.rx_line)
                        begin
                            if (q_q.rx_bits != BREAK_RX_SAT)
                            begin
                                q_d.rx_bits = q_q.rx_bits + 5'd1;
                            end
                        end
                        else
                        begin
                            if (q_q.rx_bits >= BREAK_RX_VALID)
                            begin
                                q_d.rx_done = 1'b1;
                                q_d.break_rx_enable = 1'b0;
                                q_d.break_rx_flag = 1'b0;
                            end
                            q_d.rx_state = RX_IDLE;
                            q_d.rx_cnt = 8'h00;
                            q_d.rx_half = 1'b0;
                        end
                    end
                end
                default: q_d.rx_state = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_q <= '0;
            q_q.divisor <= DIV_RESET;
            q_q.rx_buffer <= RX_BUF_RESET;
            q_q.tx_pin <= 1'b1;
            q_q.filt_s1 <= 1'b1;
            q_q.filt_s2 <= 1'b1;
            q_q.rx_line <= 1'b1;
            q_q.rx_prev <= 1'b1;
        end
        else
        begin
            q_q <= q_d;
        end
    end

    assign prdata = q_q.prdata;
    assign pready = q_q.pready;
    assign pslverr = q_q.pslverr;
    assign serial_out_pin = q_q.tx_pin;
    assign tx_done_irq = q_q.tx_done;
    assign rx_done_irq = q_q.rx_done;
    assign rx_err_irq = q_q.rx_err;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_filter_agree: assert property ($changed(q_q.rx_line) |->
        $past(q_q.filt_s1) == $past(q_q.filt_s2) && $past(q_q.base_tick))
        else $error("filtered line changed without two equal samples");
    chk_base_gated: assert property (!q_q.unit_power_bit |=> !q_q.base_tick)
        else $error("base clock ran with power off");
    chk_tx_cnt_hold: assert property
        (!(q_q.unit_power_bit && q_q.tx_enable_bit) |=> q_q.tx_cnt == 8'h00)
        else $error("transmit counter not held at zero");
    chk_rx_cnt_hold: assert property
        (q_q.rx_state == RX_IDLE |-> q_q.rx_cnt == 8'h00)
        else $error("receive counter ran outside a frame");
    chk_break_low: assert property (q_q.tx_state == TX_BREAK |-> !serial_out_pin)
        else $error("line not low during break");
    chk_break_done: assert property ($fell(q_q.break_tx_trigger) |-> tx_done_irq)
        else $error("break end without transmit interrupt");
    chk_rxbuf_kept: assert property (q_q.rx_state == RX_BREAK |=> $stable(q_q.rx_buffer))
        else $error("receive buffer changed during break");
    chk_break_errs: assert property (q_q.rx_state == RX_BREAK |=>
        (q_q.rx_error_status & ~$past(q_q.rx_error_status)) == 3'h0)
        else $error("error flag set during break");
    chk_flag_clear: assert property ($fell(q_q.break_rx_flag) |-> rx_done_irq)
        else $error("break flag cleared without receive interrupt");
    chk_merge_route: assert property (rx_err_irq |-> !$past(q_q.err_irq_merge_sel))
        else $error("separate error interrupt while merged");
    chk_div_floor: assert property (q_q.divisor >= DIV_MIN)
        else $error("divisor below minimum");

    cov_break_tx: cover property ($fell(q_q.break_tx_trigger));
    cov_break_rx: cover property ($fell(q_q.break_rx_flag));
    cov_short_break: cover property
        ($past(q_q.rx_state) == RX_BREAK && q_q.rx_state == RX_IDLE && q_q.break_rx_flag);
    cov_frame_back: cover property (q_q.tx_state == TX_GAP);

endmodule

// ===== dv/remote_node.sv
`timescale 1ns/1ps
module remote_node (
    input wire logic pclk,
    input wire logic line_in,
    output logic line_out,
    output int low_len
);
    int run;
    // The far end's line is pulled high, so a released line reads high
    initial line_out = 1'b1;
    // Length of each low stretch of the device's line, in pclk cycles
    always @(posedge pclk)
    begin
        if (line_in === 1'b0)
            run <= run + 1;
        else if (run != 0)
        begin
            low_len <= run;
            run <= 0;
        end
    end
    task automatic send_low(input int n);
        @(posedge pclk);
        line_out <= 1'b0;
        repeat (n) @(posedge pclk);
        line_out <= 1'b1;
    endtask
    // Start, eight data bits LSB first, stop; the line is released high afterwards
    task automatic send_frame(input logic [9:0] bits, input int bit_len);
        int i;
        for (i = 0; i < 10; i++)
        begin
            @(posedge pclk);
            line_out <= bits[i];
            repeat (bit_len - 1) @(posedge pclk);
        end
        @(posedge pclk);
        line_out <= 1'b1;
    endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import uart_lin_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, st = 32'h406C7D9E;
    logic pready, pslverr, sin, sout, txi, rxi, erri;
    logic [2:0] len;
    logic [7:0] b;
    logic [32:0] exq[$];
    int bad_count, n_compared, ntx, nrx, nerr, blen;
    always #50 pclk = ~pclk;
    uart_lin_break_and_baud_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_pin(sin), .serial_out_pin(sout),
        .tx_done_irq(txi), .rx_done_irq(rxi), .rx_err_irq(erri));
    remote_node peer (.pclk(pclk), .line_in(sout), .line_out(sin), .low_len(blen));
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Pready is read just after the rising edge, before the slave's update lands,
    // so the request is released at the very edge that saw it high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge pclk);
        if (pready !== 1'b1)
        begin
            bad_count++;
            give_verdict();
        end
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_irq(input int which);
        int i;
        for (i = 0; i < 1000 && (which == 0 ? ntx : which == 1 ? nrx : nerr) == 0; i++)
            @(negedge pclk);
        if (i == 1000)
        begin
            bad_count++;
            give_verdict();
        end
    endtask
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check("read", {pslverr, prdata}, exq.pop_front());
        if (txi === 1'b1)
            ntx++;
        if (rxi === 1'b1)
            nrx++;
        if (erri === 1'b1)
            nerr++;
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_DIV, 33'h0FF);
        rd(ADDR_RXBUF, 33'h0FF);
        rd(8'hFC, 33'h100000000);
        apb(1'b1, ADDR_MODE, 32'h40);
        rd(ADDR_MODE, 33'h0);
        apb(1'b1, ADDR_MODE, 32'h80);
        apb(1'b1, ADDR_MODE, 32'hE0);
        rd(ADDR_MODE, 33'h0E0);
        apb(1'b1, ADDR_CLKSEL, 32'h0);
        apb(1'b1, ADDR_DIV, 32'h4);
        st = xorshift(st);
        len = st[2:0];
        b = st[10:3];
        apb(1'b1, ADDR_CTL, {27'h1, len, 2'b00});
        wait_irq(1'b0);
        repeat (2) @(posedge pclk);
        check("break low", 33'(blen), 33'((13 + len) * 8));
        rd(ADDR_CTL, {28'h0, len, 2'b00});
        rd(ADDR_TXSTAT, 33'h0);
        apb(1'b1, ADDR_CTL, 32'h40);
        peer.send_low(64);
        repeat (100) @(posedge pclk);
        check("short break irq", 33'(nrx), 33'h0);
        rd(ADDR_CTL, 33'h0C0);
        peer.send_low(96);
        wait_irq(1'b1);
        rd(ADDR_CTL, 33'h0);
        rd(ADDR_ERR, 33'h0);
        rd(ADDR_RXBUF, 33'h0FF);
        check("break err irq", 33'(nerr), 33'h0);
        nrx = 0;
        peer.send_frame({1'b1, b, 1'b0}, 8);
        wait_irq(1);
        rd(ADDR_RXBUF, 33'(b));
        peer.send_frame({1'b0, ~b, 1'b0}, 8);
        wait_irq(2);
        check("split err irq", 33'(nrx), 33'h1);
        rd(ADDR_ERR, 33'h4);
        apb(1'b1, ADDR_MODE, 32'hE1);
        nrx = 0;
        nerr = 0;
        peer.send_frame({1'b0, b, 1'b0}, 8);
        wait_irq(1);
        check("merged err irq", 33'(nerr), 33'h0);
        rd(ADDR_ERR, 33'h5);
        give_verdict();
    end
endmodule
